// file: hdl/sdcm_pkg.sv
// package: constants for the communication setup selector
package sdcm_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_SETUP = 8'h08;
   localparam logic [7:0] OFS_DIR = 8'h0c;
   localparam logic [7:0] OFS_CMD = 8'h10;
   localparam logic [7:0] OFS_RESP = 8'h14;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
   localparam logic [7:0] OFS_ACTIVE = 8'h20;
   // setup word field positions
   localparam int SU_ADDR_LSB = 0;
   localparam int SU_BAUD_LSB = 8;
   localparam int SU_PAR_LSB = 12;
   localparam int SU_LF_BIT = 14;
   localparam int SU_ECHO_BIT = 15;
   localparam int SU_DLY_LSB = 16;
   // baud and parity codes
   localparam logic [3:0] BAUD_300 = 4'h0;
   localparam logic [1:0] PAR_NONE = 2'h0;
   // factory setup: address '1', 300 baud, no lf, no parity, no echo, delay 2
   localparam logic [7:0] FACT_ADDR = 8'h31;
   localparam logic [3:0] FACT_DLY = 4'h2;
   localparam logic [31:0] SETUP_RESET = 32'h0002_0031;
   localparam logic [14:0] DIR_RESET = 15'h0000;
   localparam int NCHAN = 15;
   // illegal address characters, and the '?' error reply prefix
   localparam logic [7:0] CH_NUL = 8'h00;
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_DOLLAR = 8'h24;
   localparam logic [7:0] CH_HASH = 8'h23;
   localparam logic [7:0] CH_QMARK = 8'h3f;
   // command decode
   localparam logic [1:0] CMD_READ_SETUP = 2'h1;
   localparam logic [1:0] CMD_WRITE_SETUP = 2'h2;
   localparam logic [1:0] CMD_OTHER = 2'h3;
   // program reset pulse length in cycles
   localparam int RST_NS = 100;
   localparam int RST_CYC = (RST_NS + 9) / 10;
   // interrupt status bits
   localparam int IRQ_ACCEPT = 0;
   localparam int IRQ_ERROR = 1;
   localparam int IRQ_PRESET = 2;
   // address legality check
   function automatic logic addr_legal(input logic [7:0] c);
      addr_legal = (c != CH_NUL) && (c != CH_CR) && (c != CH_DOLLAR) && (c != CH_HASH);
   endfunction
endpackage

// file: hdl/sdcm_addr_match.sv
// address matcher: stored address or any legal address when forced
`timescale 1ns/100ps
`default_nettype none
module sdcm_addr_match (
   // command address and mode
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] own_addr,
   input wire logic forced,
   // result
   output logic hit
);
   wire legal = sdcm_pkg::addr_legal(cmd_addr);
   // forced mode accepts any legal address
   assign hit = legal && (forced || (cmd_addr == own_addr)); // R3
endmodule
`default_nettype wire

// file: hdl/sdcm_rst_gen.sv
// program reset pulse generator on override release
`timescale 1ns/100ps
`default_nettype none
module sdcm_rst_gen (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // forced mode level
   input wire logic forced,
   // program reset pulse, held RST_CYC cycles
   output logic prog_rst
);
   logic forced_q;
   logic [3:0] cnt;
   wire release_ev = forced_q && !forced;
   // start count on release of override pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         forced_q <= 1'b0;
         cnt <= 4'h0;
      end else begin
         forced_q <= forced;
         if (release_ev) begin
            cnt <= 4'(sdcm_pkg::RST_CYC - 1); // R7
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
   // pulse already high in the release cycle, so the active setup cannot move before it
   assign prog_rst = release_ev || (cnt != 4'h0);
endmodule
`default_nettype wire

// file: hdl/sdcm_top.sv
// top: communication setup selection, address match and registers
// Function
// R1: forced mode runs 300 baud 8N1
// R2: low override pin enters forced mode
// R3: forced mode accepts any legal address
// R4: override leaves stored setup unchanged
// R5: all commands execute in forced mode
// R6: write-setup in forced updates stored only
// R7: release causes program reset then stored
// R8: error reply sends own address after '?'
// R9: read-setup returns all stored values; the setup word read omits the channel directions
// R10: host always sends an address
// R11: power-up applies stored channel directions
// R12: each channel direction individually settable
// R13: factory setup address 1, 300 baud
// R14: transmit only in reply to command
// R15: host ends commands with carriage return
`timescale 1ns/100ps
`default_nettype none
module sdcm_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // override pin, active low
   input wire logic override_n,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // active serial configuration
   output logic [3:0] act_baud,
   output logic [1:0] act_parity,
   // channel directions, 1 = output
   output logic [14:0] chan_dir,
   // interrupt
   output logic irq
);
   ////////////////////////////////////////////////////////////////
   // state
   logic [31:0] setup;
   logic [14:0] dir;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [15:0] resp;
   logic resp_valid;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic aw_got, w_got, bvalid_q, rvalid_q;
   logic [7:0] aw_q;
   logic [31:0] w_q;
   logic [3:0] ws_q;
   logic forced;
   logic hit;
   logic prog_rst;
   logic dir_loaded;

   ////////////////////////////////////////////////////////////////
   // mode selection
   // low pin forces known setup
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         forced <= 1'b0;
      end else begin
         forced <= !override_n; // R2
      end
   end

   // active config: forced 300 8N1, else stored (held during program reset)
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_baud <= sdcm_pkg::BAUD_300;
         act_parity <= sdcm_pkg::PAR_NONE;
      end else if (forced) begin
         act_baud <= sdcm_pkg::BAUD_300; // R1
         act_parity <= sdcm_pkg::PAR_NONE; // R1
      end else if (!prog_rst) begin
         act_baud <= setup[sdcm_pkg::SU_BAUD_LSB +: 4]; // R7
         act_parity <= setup[sdcm_pkg::SU_PAR_LSB +: 2]; // R7
      end
   end

   sdcm_rst_gen u_rst (
      .aclk(aclk),
      .aresetn(aresetn),
      .forced(forced),
      .prog_rst(prog_rst)
   );

   ////////////////////////////////////////////////////////////////
   // axi4-lite write path
   wire aw_hs = s_axi_awvalid && s_axi_awready;
   wire w_hs = s_axi_wvalid && s_axi_wready;
   assign s_axi_awready = !aw_got && !bvalid_q;
   assign s_axi_wready = !w_got && !bvalid_q;
   wire [7:0] wa = aw_hs ? s_axi_awaddr : aw_q;
   wire [31:0] wd = w_hs ? s_axi_wdata : w_q;
   wire [3:0] wsb = w_hs ? s_axi_wstrb : ws_q;
   wire wr_go = (aw_got || aw_hs) && (w_got || w_hs);
   wire wr_known = (wa == sdcm_pkg::OFS_CTRL) || (wa == sdcm_pkg::OFS_DIR) ||
      (wa == sdcm_pkg::OFS_CMD) || (wa == sdcm_pkg::OFS_IRQ_STAT) ||
      (wa == sdcm_pkg::OFS_IRQ_MASK);
   wire [31:0] wmask = {{8{wsb[3]}}, {8{wsb[2]}}, {8{wsb[1]}}, {8{wsb[0]}}};

   // command register: [7:0] address char, [9:8] command kind
   wire cmd_wr = wr_go && (wa == sdcm_pkg::OFS_CMD);
   wire [7:0] cmd_addr = wd[7:0];
   wire [1:0] cmd_kind = wd[9:8];
   wire [31:0] cmd_setup = setup & ~wmask | {8'h00, wd[31:10], 2'b00} & wmask;

   sdcm_addr_match u_match (
      .cmd_addr(cmd_addr),
      .own_addr(setup[sdcm_pkg::SU_ADDR_LSB +: 8]),
      .forced(forced),
      .hit(hit)
   );

   // unmatched or invalid command kind: error if address matched
   wire cmd_ok = cmd_wr && hit && (cmd_kind != 2'h0); // R5
   wire cmd_err = cmd_wr && hit && (cmd_kind == 2'h0);

   // handshake capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         bvalid_q <= 1'b0;
         aw_q <= 8'h00;
         w_q <= 32'h0000_0000;
         ws_q <= 4'h0;
      end else begin
         if (aw_hs) begin
            aw_q <= s_axi_awaddr;
         end
         if (w_hs) begin
            w_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            bvalid_q <= 1'b1;
         end else begin
            aw_got <= aw_got || aw_hs;
            w_got <= w_got || w_hs;
            if (s_axi_bready) begin
               bvalid_q <= 1'b0;
            end
         end
      end
   end
   logic bresp_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bresp_q <= 1'b0;
      end else if (wr_go) begin
         bresp_q <= !wr_known;
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q ? 2'b10 : 2'b00;

   ////////////////////////////////////////////////////////////////
   // stored setup and directions
   // setup changes only by write-setup command, never by the pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         setup <= sdcm_pkg::SETUP_RESET; // R13
         dir <= sdcm_pkg::DIR_RESET;
      end else begin
         if (cmd_ok && cmd_kind == sdcm_pkg::CMD_WRITE_SETUP) begin
            setup <= cmd_setup; // R4 R6
         end
         if (wr_go && wa == sdcm_pkg::OFS_DIR) begin
            dir <= (dir & ~wmask[14:0]) | (wd[14:0] & wmask[14:0]); // R12
         end
      end
   end

   // stored directions drive channels once out of reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dir_loaded <= 1'b0;
         chan_dir <= 15'h0000;
      end else begin
         dir_loaded <= 1'b1;
         if (dir_loaded) begin
            chan_dir <= dir; // R11
         end
      end
   end

   // read address taken this cycle
   wire rd_go = s_axi_arvalid && s_axi_arready;

   ////////////////////////////////////////////////////////////////
   // responses: only in reply to an addressed command
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         resp <= 16'h0000;
         resp_valid <= 1'b0;
      end else if (cmd_err) begin
         resp <= {sdcm_pkg::CH_QMARK, setup[sdcm_pkg::SU_ADDR_LSB +: 8]}; // R8
         resp_valid <= 1'b1; // R14
      end else if (cmd_ok) begin
         resp <= {8'h2a, 8'h00};
         resp_valid <= 1'b1; // R14
      end else if (rd_go && s_axi_araddr == sdcm_pkg::OFS_RESP) begin
         resp_valid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // interrupts: sticky, write one to clear, set wins
   wire [2:0] irq_set = {prog_rst, cmd_err, cmd_ok};
   wire [2:0] irq_clr = (wr_go && wa == sdcm_pkg::OFS_IRQ_STAT) ? (wd[2:0] & wmask[2:0]) : 3'h0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat <= 3'h0;
         irq_mask <= 3'h0;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
         if (wr_go && wa == sdcm_pkg::OFS_IRQ_MASK) begin
            irq_mask <= wd[2:0];
         end
      end
   end
   assign irq = |(irq_stat & irq_mask);

   ////////////////////////////////////////////////////////////////
   // axi4-lite read path
   assign s_axi_arready = !rvalid_q;
   wire [31:0] status_word = {28'h0, prog_rst, resp_valid, 1'b0, forced};
   wire [31:0] active_word = {26'h0, act_parity, act_baud};
   wire rd_known = (s_axi_araddr <= sdcm_pkg::OFS_ACTIVE) && (s_axi_araddr[1:0] == 2'b00);
   // read mux; setup word returns every stored setup field, not the channel directions
   wire [31:0] rd_mux =
      (s_axi_araddr == sdcm_pkg::OFS_CTRL) ? 32'h0000_0000 :
      (s_axi_araddr == sdcm_pkg::OFS_STATUS) ? status_word :
      (s_axi_araddr == sdcm_pkg::OFS_SETUP) ? setup : // R9
      (s_axi_araddr == sdcm_pkg::OFS_DIR) ? {17'h0, dir} :
      (s_axi_araddr == sdcm_pkg::OFS_RESP) ? {16'h0, resp} :
      (s_axi_araddr == sdcm_pkg::OFS_IRQ_STAT) ? {29'h0, irq_stat} :
      (s_axi_araddr == sdcm_pkg::OFS_IRQ_MASK) ? {29'h0, irq_mask} :
      (s_axi_araddr == sdcm_pkg::OFS_ACTIVE) ? active_word : 32'h0000_0000;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= 2'b00;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_known ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   ////////////////////////////////////////////////////////////////
   // assertions
   property p_forced_cfg;
      @(posedge aclk) disable iff (!aresetn)
      forced |=> (act_baud == sdcm_pkg::BAUD_300) && (act_parity == sdcm_pkg::PAR_NONE);
   endproperty
   a_forced_cfg: assert property (p_forced_cfg) else $error("forced config not 300 8N1"); // R1
   property p_pin;
      @(posedge aclk) disable iff (!aresetn)
      !override_n ##1 !override_n |-> forced;
   endproperty
   a_pin: assert property (p_pin) else $error("pin low but not forced"); // R2
   property p_any_addr;
      @(posedge aclk) disable iff (!aresetn)
      (forced && cmd_wr && sdcm_pkg::addr_legal(cmd_addr)) |-> hit;
   endproperty
   a_any_addr: assert property (p_any_addr) else $error("legal address refused in forced"); // R3
   property p_illegal;
      @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && !sdcm_pkg::addr_legal(cmd_addr)) |=> !resp_valid || $stable(resp);
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal address answered"); // R3
   property p_setup_keep;
      @(posedge aclk) disable iff (!aresetn)
      !(cmd_ok && cmd_kind == sdcm_pkg::CMD_WRITE_SETUP) |=> $stable(setup);
   endproperty
   a_setup_keep: assert property (p_setup_keep) else $error("setup changed without command"); // R4
   property p_release;
      @(posedge aclk) disable iff (!aresetn)
      $fell(forced) |-> ##[1:2] prog_rst;
   endproperty
   a_release: assert property (p_release) else $error("no program reset on release"); // R7
   property p_err_addr;
      @(posedge aclk) disable iff (!aresetn)
      cmd_err |=> resp == {sdcm_pkg::CH_QMARK, $past(setup[7:0])};
   endproperty
   a_err_addr: assert property (p_err_addr) else $error("error reply lacks address"); // R8
   property p_no_unsolicited;
      @(posedge aclk) disable iff (!aresetn)
      $rose(resp_valid) |-> $past(cmd_ok || cmd_err);
   endproperty
   a_no_unsolicited: assert property (p_no_unsolicited) else $error("unsolicited reply"); // R14
   property p_dir;
      @(posedge aclk) disable iff (!aresetn)
      dir_loaded ##1 dir_loaded |-> chan_dir == $past(dir);
   endproperty
   a_dir: assert property (p_dir) else $error("directions not applied"); // R11 R12
   // active config frozen while the program reset runs
   property p_rst_hold;
      @(posedge aclk) disable iff (!aresetn)
      prog_rst |=> $stable(act_baud) && $stable(act_parity);
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("active config moved during program reset"); // R7
   // stored baud rate active outside forced mode and program reset
   property p_act_stored;
      @(posedge aclk) disable iff (!aresetn)
      !forced && !prog_rst |=> act_baud == $past(setup[sdcm_pkg::SU_BAUD_LSB +: 4]);
   endproperty
   a_act_stored: assert property (p_act_stored) else $error("stored baud rate not active"); // R7
   c_forced_setup: cover property (@(posedge aclk) disable iff (!aresetn)
      forced && cmd_ok && cmd_kind == sdcm_pkg::CMD_WRITE_SETUP);
   c_forced_cmd: cover property (@(posedge aclk) disable iff (!aresetn) forced && cmd_ok);
   c_error: cover property (@(posedge aclk) disable iff (!aresetn) cmd_err);
   c_release: cover property (@(posedge aclk) disable iff (!aresetn) $fell(forced) ##[1:3] prog_rst);
endmodule
`default_nettype wire

// file: sim/sdcm_host_model.sv
// host model: axi4-lite master sending register and command transfers
`timescale 1ns/100ps
`default_nettype none
module sdcm_host_model (
   // clock
   input wire logic aclk,
   // write channels
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // read channels
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // idle bus at time zero
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} <= '0;
      {araddr, arvalid, rready} <= '0;
   end
   ////////////////////////////////////////////////////////////////
   // one write: address and data together, then the response
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      @(posedge aclk);
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge aclk);
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   // one read: address, then data held until taken
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
      end while (!arready);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // one complete command, always with an address character
   task automatic cmd(input logic [7:0] ch, input logic [1:0] kind, input logic [31:0] wd);
      logic [1:0] r;
      wr(sdcm_pkg::OFS_CMD, {wd[31:10], kind, ch}, 4'hf, r);
   endtask
endmodule
`default_nettype wire

// file: sim/safe_default_comm_mode_tb.sv
// testbench: forced setup, address match, setup store and interrupts
`timescale 1ns/100ps
`default_nettype none
module safe_default_comm_mode_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic override_n = 1'b1;
   logic [7:0] awaddr;
   logic [7:0] araddr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp;
   logic [1:0] rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [3:0] act_baud;
   logic [1:0] act_parity;
   logic [14:0] chan_dir;
   logic irq;
   logic [31:0] d;
   logic [1:0] r;
   int err_total = 0;
   int comparisons = 0;
   int cyc = 0;
   // 100 mhz clock
   always #5 aclk = ~aclk;
   sdcm_top i_dut (.aclk(aclk), .aresetn(aresetn), .override_n(override_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .act_baud(act_baud), .act_parity(act_parity), .chan_dir(chan_dir), .irq(irq));
   sdcm_host_model i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   ////////////////////////////////////////////////////////////////
   // compare and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      i_host.rd(a, d, r);
      chk(d & m, exp);
   endtask
   // read interrupt status, then clear it
   task automatic stat(input logic [31:0] exp);
      rchk(sdcm_pkg::OFS_IRQ_STAT, 32'h7, exp);
      i_host.wr(sdcm_pkg::OFS_IRQ_STAT, 32'h7, 4'hf, r);
   endtask
   ////////////////////////////////////////////////////////////////
   // reset values and an unmapped read
   task automatic t_reset();
      i_host.wr(sdcm_pkg::OFS_SETUP, 32'h0000_0000, 4'hf, r);
      chk(r, 2'h2);
      rchk(sdcm_pkg::OFS_SETUP, 32'hffffffff, sdcm_pkg::SETUP_RESET);
      chk({act_parity, act_baud}, {sdcm_pkg::PAR_NONE, sdcm_pkg::BAUD_300});
      chk(chan_dir, sdcm_pkg::DIR_RESET);
      i_host.rd(8'h40, d, r);
      chk(r, 2'h2);
      chk(d, 32'h0);
      chk(irq, 1'b0);
   endtask
   // per channel directions with byte strobes
   task automatic t_dir();
      i_host.wr(sdcm_pkg::OFS_DIR, 32'h5a5a, 4'hf, r);
      chk(r, 2'h0);
      @(posedge aclk); // channel outputs follow the stored word one cycle later
      chk(chan_dir, 15'h5a5a);
      i_host.wr(sdcm_pkg::OFS_DIR, 32'hffff, 4'h1, r);
      @(posedge aclk);
      chk(chan_dir, 15'h5aff);
      rchk(sdcm_pkg::OFS_DIR, 32'h7fff, 32'h5aff);
   endtask
   // normal mode: own address only, error reply, interrupt mask
   task automatic t_poll();
      i_host.wr(sdcm_pkg::OFS_IRQ_MASK, 32'h7, 4'hf, r);
      i_host.cmd(8'h32, 2'h1, 32'h0);
      stat(32'h0);
      i_host.cmd(sdcm_pkg::FACT_ADDR, 2'h1, 32'h0);
      stat(32'h1);
      i_host.cmd(sdcm_pkg::FACT_ADDR, 2'h0, 32'h0);
      chk(irq, 1'b1);
      rchk(sdcm_pkg::OFS_STATUS, 32'h4, 32'h4);
      rchk(sdcm_pkg::OFS_RESP, 32'hffff, {16'h0, sdcm_pkg::CH_QMARK, sdcm_pkg::FACT_ADDR});
      i_host.wr(sdcm_pkg::OFS_IRQ_MASK, 32'h0, 4'hf, r);
      chk(irq, 1'b0);
      stat(32'h2);
   endtask
   // forced mode: fixed frame, any legal address, stored setup only
   task automatic t_forced();
      logic [7:0] bad [4] = '{sdcm_pkg::CH_NUL, sdcm_pkg::CH_CR, sdcm_pkg::CH_DOLLAR, sdcm_pkg::CH_HASH};
      override_n <= 1'b0;
      repeat (3) @(posedge aclk);
      chk({act_parity, act_baud}, 6'h0);
      rchk(sdcm_pkg::OFS_STATUS, 32'h1, 32'h1);
      rchk(sdcm_pkg::OFS_SETUP, 32'hffffffff, sdcm_pkg::SETUP_RESET);
      i_host.cmd(8'h7a, 2'h1, 32'h0);
      stat(32'h1);
      foreach (bad[i]) begin
         i_host.cmd(bad[i], 2'h1, 32'h0);
         stat(32'h0);
      end
      i_host.cmd(8'h7a, 2'h3, 32'h0);
      stat(32'h1);
      i_host.cmd(8'h41, 2'h0, 32'h0);
      stat(32'h2);
      rchk(sdcm_pkg::OFS_RESP, 32'hffff, {16'h0, sdcm_pkg::CH_QMARK, sdcm_pkg::FACT_ADDR});
      // setup field lands in setup[23:2]: address 0x30, baud 0xc, parity 1, delay 2
      i_host.cmd(sdcm_pkg::FACT_ADDR, 2'h2, 32'h021c_3000);
      chk({act_parity, act_baud}, 6'h0);
      rchk(sdcm_pkg::OFS_SETUP, 32'hffffffff, 32'h0002_1c30);
   endtask
   // release: program reset, then the stored setup is active
   task automatic t_release();
      override_n <= 1'b1;
      repeat (4) @(posedge aclk);
      rchk(sdcm_pkg::OFS_STATUS, 32'h8, 32'h8);
      repeat (12) @(posedge aclk);
      chk({act_parity, act_baud}, 6'h1c);
      rchk(sdcm_pkg::OFS_ACTIVE, 32'h3f, 32'h1c);
      rchk(sdcm_pkg::OFS_IRQ_STAT, 32'h4, 32'h4);
      rchk(sdcm_pkg::OFS_STATUS, 32'h1, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////
   // verdict
   task automatic complete_run();
      if (err_total == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   // main sequence
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_dir();
      t_poll();
      t_forced();
      t_release();
      complete_run();
   end
endmodule
`default_nettype wire
